// ---- hw/fim_params.svh ----
// timing counts, field positions and reset values of the flash interface front end
`ifndef FIM_PARAMS_SVH
`define FIM_PARAMS_SVH
`define FIM_NIB_START      4'h0
`define FIM_NIB_SYNC       4'h0
`define FIM_NIB_TAR        4'hF
`define FIM_CYC_MEM        2'h1
`define FIM_ADDR_NIBS      3'h7
`define FIM_ADDR_MEM_BIT   22
`define FIM_ADDR_ID_LSB    23
`define FIM_ROW_W          11
`define FIM_SYNC_WAIT      8'h10
`define FIM_RST_RB_N       1'b1
`endif

// ---- hw/fim_pkg.sv ----
// state types of the device end and of the host end of the flash interface front end
package fim_pkg;
    typedef enum logic [7:0] {
        D_IDLE = 8'h01,
        D_CYC  = 8'h02,
        D_ADDR = 8'h04,
        D_WDAT = 8'h08,
        D_TARH = 8'h10,
        D_SYNC = 8'h20,
        D_RDAT = 8'h40,
        D_TARD = 8'h80
    } fim_dev_st_t;

    typedef enum logic [11:0] {
        H_IDLE  = 12'h001,
        H_START = 12'h002,
        H_CYC   = 12'h004,
        H_ADDR  = 12'h008,
        H_WDAT  = 12'h010,
        H_TAR   = 12'h020,
        H_SYNC  = 12'h040,
        H_RDAT  = 12'h080,
        H_TARE  = 12'h100,
        H_ROW   = 12'h200,
        H_COL   = 12'h400,
        H_PACC  = 12'h800
    } fim_host_st_t;
endpackage

// ---- hw/fim_if.sv ----
// pin bundle between the flash front end and its host or programmer
`timescale 1ns/10ps
interface fim_if;
    logic [3:0]  lad_host_o;
    logic        lad_host_oe;
    logic [3:0]  lad_dev_o;
    logic        lad_dev_oe;
    logic [3:0]  lad;
    logic        lframe_n;
    logic        mode_level;
    logic        mode_connected;
    logic [3:0]  chip_identity_strap;
    logic [4:0]  general_purpose_inputs;
    logic        rst_n;
    logic        init_n;
    logic [10:0] addr;
    logic        row_col_sel;
    logic        oe_n;
    logic        we_n;
    logic [7:0]  data_host_o;
    logic        data_host_oe;
    logic [7:0]  data_dev_o;
    logic        data_dev_oe;
    logic [7:0]  data;
    logic        ready_busy_n;

    // floating bus reads high
    assign lad  = lad_dev_oe ? lad_dev_o : (lad_host_oe ? lad_host_o : 4'hF);
    assign data = data_dev_oe ? data_dev_o : (data_host_oe ? data_host_o : 8'hFF);

    modport dev (
        input  lad, lframe_n, mode_level, mode_connected, chip_identity_strap,
               general_purpose_inputs, rst_n, init_n, addr, row_col_sel, oe_n, we_n, data,
        output lad_dev_o, lad_dev_oe, data_dev_o, data_dev_oe, ready_busy_n
    );
    modport host (
        input  lad, data, ready_busy_n,
        output lad_host_o, lad_host_oe, lframe_n, mode_level, mode_connected,
               chip_identity_strap, general_purpose_inputs, rst_n, init_n, addr,
               row_col_sel, oe_n, we_n, data_host_o, data_host_oe
    );
endinterface

// ---- hw/fim_dev.sv ----
// flash front end, device end: strap mode select, serial and parallel ports
`timescale 1ns/10ps
`include "fim_params.svh"
module fim_dev #(
    parameter int MEM_AW      = 8,
    parameter int PROG_CYCLES = 64
) (
    input  wire logic core_clk,
    input  wire logic reset,
    fim_if.dev        pins
);
    import fim_pkg::*;

    typedef struct packed {
        fim_dev_st_t st;
        logic [2:0]  cnt;
        logic        dir_wr;
        logic [31:0] addr;
        logic [7:0]  wdat;
        logic [7:0]  rdat;
        logic [3:0]  lad_o;
        logic        lad_oe;
        logic [10:0] row;
        logic [10:0] col;
        logic        we_d;
        logic [15:0] busy_cnt;
        logic        rb_n;
        logic [7:0]  pdata_o;
    } fim_dev_state_t;

    localparam fim_dev_state_t RST_VAL = '{
        st: D_IDLE, cnt: 3'h0, dir_wr: 1'b0, addr: 32'h0, wdat: 8'h0, rdat: 8'h0,
        lad_o: 4'hF, lad_oe: 1'b0, row: 11'h0, col: 11'h0, we_d: 1'b1,
        busy_cnt: 16'h0, rb_n: `FIM_RST_RB_N, pdata_o: 8'h0
    };

    fim_dev_state_t q_r;
    fim_dev_state_t q_nxt;
    logic [7:0]     mem [2**MEM_AW];
    logic           mem_we;
    logic [MEM_AW-1:0] mem_wa;
    logic [7:0]     mem_wd;
    logic           dev_rst;
    logic           par_mode;
    logic [31:0]    addr_full;
    logic [21:0]    par_addr;

    assign dev_rst   = reset | ~pins.rst_n | ~pins.init_n;
    assign par_mode  = pins.mode_connected & pins.mode_level;
    assign addr_full = {q_r.addr[27:0], pins.lad};
    assign par_addr  = {q_r.col, q_r.row};

    always_comb begin
        q_nxt  = q_r;
        mem_we = 1'b0;
        mem_wa = '0;
        mem_wd = '0;
        if (q_r.busy_cnt != 16'h0) begin
            q_nxt.busy_cnt = q_r.busy_cnt - 16'h1;
        end
        q_nxt.we_d = pins.we_n;
        if (!par_mode) begin
            unique case (q_r.st)
                D_IDLE: begin
                    if (!pins.lframe_n && pins.lad == `FIM_NIB_START) begin
                        q_nxt.st = D_CYC;
                    end
                end
                D_CYC: begin
                    if (!pins.lframe_n) begin
                        if (pins.lad != `FIM_NIB_START) begin
                            q_nxt.st = D_IDLE;
                        end
                    end else if (pins.lad[3:2] == `FIM_CYC_MEM) begin
                        q_nxt.dir_wr = pins.lad[1];
                        q_nxt.cnt    = 3'h0;
                        q_nxt.st     = D_ADDR;
                    end else begin
                        q_nxt.st = D_IDLE;
                    end
                end
                D_ADDR: begin
                    q_nxt.addr = addr_full;
                    q_nxt.cnt  = q_r.cnt + 3'h1;
                    if (q_r.cnt == `FIM_ADDR_NIBS) begin
                        q_nxt.cnt = 3'h0;
                        if (addr_full[`FIM_ADDR_ID_LSB+:4] != pins.chip_identity_strap) begin
                            q_nxt.st = D_IDLE;
                        end else if (q_r.dir_wr) begin
                            q_nxt.st = D_WDAT;
                        end else begin
                            q_nxt.st   = D_TARH;
                            q_nxt.rdat = addr_full[`FIM_ADDR_MEM_BIT] ?
                                         mem[addr_full[MEM_AW-1:0]] :
                                         {3'h0, pins.general_purpose_inputs};
                        end
                    end
                end
                D_WDAT: begin
                    q_nxt.cnt = q_r.cnt + 3'h1;
                    if (q_r.cnt == 3'h0) begin
                        q_nxt.wdat[3:0] = pins.lad;
                    end else begin
                        q_nxt.wdat[7:4] = pins.lad;
                        q_nxt.cnt       = 3'h0;
                        q_nxt.st        = D_TARH;
                        if (q_r.addr[`FIM_ADDR_MEM_BIT] && q_r.busy_cnt == 16'h0) begin
                            mem_we         = 1'b1;
                            mem_wa         = q_r.addr[MEM_AW-1:0];
                            mem_wd         = {pins.lad, q_r.wdat[3:0]};
                            q_nxt.busy_cnt = 16'(PROG_CYCLES);
                        end
                    end
                end
                D_TARH: begin
                    q_nxt.cnt = q_r.cnt + 3'h1;
                    if (q_r.cnt == 3'h1) begin
                        q_nxt.cnt = 3'h0;
                        q_nxt.st  = D_SYNC;
                    end
                end
                D_SYNC: q_nxt.st = q_r.dir_wr ? D_TARD : D_RDAT;
                D_RDAT: begin
                    q_nxt.cnt = q_r.cnt + 3'h1;
                    if (q_r.cnt == 3'h1) begin
                        q_nxt.cnt = 3'h0;
                        q_nxt.st  = D_TARD;
                    end
                end
                D_TARD: q_nxt.st = D_IDLE;
            endcase
            if (q_r.st != D_IDLE && q_r.st != D_CYC && !pins.lframe_n) begin
                q_nxt.st  = (pins.lad == `FIM_NIB_START) ? D_CYC : D_IDLE;
                q_nxt.cnt = 3'h0;
            end
        end else begin
            q_nxt.st = D_IDLE;
            if (pins.row_col_sel) begin
                q_nxt.row = pins.addr;
            end else begin
                q_nxt.col = pins.addr;
            end
            if (!q_r.we_d && pins.we_n && q_r.busy_cnt == 16'h0) begin
                mem_we         = 1'b1;
                mem_wa         = par_addr[MEM_AW-1:0];
                mem_wd         = pins.data;
                q_nxt.busy_cnt = 16'(PROG_CYCLES);
            end
            q_nxt.pdata_o = mem[par_addr[MEM_AW-1:0]];
        end
        q_nxt.rb_n   = (q_nxt.busy_cnt == 16'h0);
        q_nxt.lad_oe = 1'b1;
        unique case (q_nxt.st)
            D_SYNC:  q_nxt.lad_o = `FIM_NIB_SYNC;
            D_RDAT:  q_nxt.lad_o = (q_nxt.cnt == 3'h0) ? q_nxt.rdat[3:0] : q_nxt.rdat[7:4];
            D_TARD:  q_nxt.lad_o = `FIM_NIB_TAR;
            default: begin
                q_nxt.lad_o  = `FIM_NIB_TAR;
                q_nxt.lad_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (dev_rst) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (mem_we && !dev_rst) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign pins.lad_dev_o    = q_r.lad_o;
    assign pins.lad_dev_oe   = q_r.lad_oe & ~par_mode;
    assign pins.data_dev_o   = q_r.pdata_o;
    assign pins.data_dev_oe  = par_mode & ~pins.oe_n;
    assign pins.ready_busy_n = q_r.rb_n;
endmodule // fim_dev

// ---- hw/fim_host.sv ----
// flash front end, host end: serial bus master and parallel programmer
`timescale 1ns/10ps
`include "fim_params.svh"
module fim_host (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_write,
    input  wire logic [31:0] cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    output logic             rsp_valid,
    output logic             rsp_error,
    output logic [7:0]       rsp_rdata,
    input  wire logic        cfg_parallel,
    input  wire logic        cfg_strap_connected,
    input  wire logic [3:0]  cfg_chip_identity,
    input  wire logic [4:0]  cfg_gpi,
    input  wire logic        cfg_init_n,
    output logic             dev_ready,
    fim_if.host              pins
);
    import fim_pkg::*;

    typedef struct packed {
        fim_host_st_t st;
        logic [7:0]   cnt;
        logic         wr;
        logic [31:0]  addr;
        logic [7:0]   wdat;
        logic [7:0]   rdat;
        logic         rsp;
        logic         err;
        logic         par;
        logic         rst_n;
        logic         frame_n;
        logic [3:0]   lad_o;
        logic         lad_oe;
        logic [10:0]  paddr;
        logic         rc;
        logic         oe_n;
        logic         we_n;
        logic         data_oe;
    } fim_host_state_t;

    localparam fim_host_state_t RST_VAL = '{
        st: H_IDLE, cnt: 8'h0, wr: 1'b0, addr: 32'h0, wdat: 8'h0, rdat: 8'h0,
        rsp: 1'b0, err: 1'b0, par: 1'b0, rst_n: 1'b0, frame_n: 1'b1, lad_o: 4'hF,
        lad_oe: 1'b0, paddr: 11'h0, rc: 1'b0, oe_n: 1'b1, we_n: 1'b1, data_oe: 1'b0
    };

    fim_host_state_t q_r;
    fim_host_state_t q_nxt;
    logic            par_eff;

    // open strap leaves the device serial, so talk serial too
    assign par_eff = q_r.par & cfg_strap_connected;

    always_comb begin
        q_nxt         = q_r;
        q_nxt.rsp     = 1'b0;
        q_nxt.rst_n   = 1'b1;
        q_nxt.par     = cfg_parallel;
        q_nxt.cnt     = q_r.cnt + 8'h1;
        unique case (q_r.st)
            H_IDLE: begin
                q_nxt.cnt = 8'h0;
                if (cmd_valid) begin
                    q_nxt.wr   = cmd_write;
                    q_nxt.addr = cmd_addr;
                    q_nxt.wdat = cmd_wdata;
                    q_nxt.err  = 1'b0;
                    q_nxt.st   = par_eff ? H_ROW : H_START;
                end
            end
            H_START: begin
                q_nxt.cnt = 8'h0;
                q_nxt.st  = H_CYC;
            end
            H_CYC: begin
                q_nxt.cnt = 8'h0;
                q_nxt.st  = H_ADDR;
            end
            H_ADDR: begin
                q_nxt.addr = {q_r.addr[27:0], q_r.addr[31:28]};
                if (q_r.cnt == 8'h7) begin
                    q_nxt.cnt = 8'h0;
                    q_nxt.st  = q_r.wr ? H_WDAT : H_TAR;
                end
            end
            H_WDAT: begin
                if (q_r.cnt == 8'h1) begin
                    q_nxt.cnt = 8'h0;
                    q_nxt.st  = H_TAR;
                end
            end
            H_TAR: begin
                if (q_r.cnt == 8'h1) begin
                    q_nxt.cnt = 8'h0;
                    q_nxt.st  = H_SYNC;
                end
            end
            H_SYNC: begin
                if (pins.lad == `FIM_NIB_SYNC) begin
                    q_nxt.cnt = 8'h0;
                    q_nxt.st  = q_r.wr ? H_TARE : H_RDAT;
                end else if (q_r.cnt == `FIM_SYNC_WAIT) begin
                    q_nxt.err = 1'b1;
                    q_nxt.rsp = 1'b1;
                    q_nxt.st  = H_IDLE;
                end
            end
            H_RDAT: begin
                if (q_r.cnt == 8'h0) begin
                    q_nxt.rdat[3:0] = pins.lad;
                end else begin
                    q_nxt.rdat[7:4] = pins.lad;
                    q_nxt.cnt       = 8'h0;
                    q_nxt.st        = H_TARE;
                end
            end
            H_TARE: begin
                if (q_r.cnt == 8'h1) begin
                    q_nxt.rsp = 1'b1;
                    q_nxt.st  = H_IDLE;
                end
            end
            H_ROW: begin
                q_nxt.cnt = 8'h0;
                q_nxt.st  = H_COL;
            end
            H_COL: begin
                q_nxt.cnt = 8'h0;
                q_nxt.st  = H_PACC;
            end
            H_PACC: begin
                if (q_r.cnt == 8'h2) begin
                    q_nxt.rdat = pins.data;
                    q_nxt.rsp  = 1'b1;
                    q_nxt.st   = H_IDLE;
                end
            end
        endcase
        // pin levels for the coming cycle
        q_nxt.frame_n = (q_nxt.st != H_START);
        q_nxt.lad_oe  = 1'b1;
        unique case (q_nxt.st)
            H_START: q_nxt.lad_o = `FIM_NIB_START;
            H_CYC:   q_nxt.lad_o = {`FIM_CYC_MEM, q_nxt.wr, 1'b0};
            H_ADDR:  q_nxt.lad_o = q_nxt.addr[31:28];
            H_WDAT:  q_nxt.lad_o = (q_nxt.cnt == 8'h0) ? q_nxt.wdat[3:0] : q_nxt.wdat[7:4];
            default: begin
                q_nxt.lad_o  = `FIM_NIB_TAR;
                q_nxt.lad_oe = (q_nxt.st == H_TAR) && (q_nxt.cnt == 8'h0);
            end
        endcase
        if (q_nxt.st == H_ROW) begin
            q_nxt.paddr = q_nxt.addr[`FIM_ROW_W-1:0];
        end else if (q_nxt.st == H_COL) begin
            q_nxt.paddr = q_nxt.addr[2*`FIM_ROW_W-1:`FIM_ROW_W];
        end
        q_nxt.rc      = (q_nxt.st == H_ROW);
        q_nxt.data_oe = (q_nxt.st == H_PACC) && q_nxt.wr;
        q_nxt.we_n    = !((q_nxt.st == H_PACC) && q_nxt.wr && q_nxt.cnt == 8'h0);
        q_nxt.oe_n    = !((q_nxt.st == H_PACC) && !q_nxt.wr);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign cmd_ready                   = (q_r.st == H_IDLE);
    assign rsp_valid                   = q_r.rsp;
    assign rsp_error                   = q_r.err;
    assign rsp_rdata                   = q_r.rdat;
    assign dev_ready                   = pins.ready_busy_n;
    assign pins.lad_host_o             = q_r.lad_o;
    assign pins.lad_host_oe            = q_r.lad_oe & ~par_eff;
    assign pins.lframe_n               = q_r.frame_n | par_eff;
    assign pins.mode_level             = q_r.par;
    assign pins.mode_connected         = cfg_strap_connected;
    assign pins.chip_identity_strap    = cfg_chip_identity;
    assign pins.general_purpose_inputs = cfg_gpi;
    assign pins.rst_n                  = q_r.rst_n;
    assign pins.init_n                 = cfg_init_n;
    assign pins.addr                   = q_r.paddr;
    assign pins.row_col_sel            = q_r.rc;
    assign pins.oe_n                   = q_r.oe_n;
    assign pins.we_n                   = q_r.we_n;
    assign pins.data_host_o            = q_r.wdat;
    assign pins.data_host_oe           = q_r.data_oe & par_eff;
endmodule // fim_host

// ---- testbench/fim_link_checker.sv ----
// pin-level checks between the two ends of the flash front end
`timescale 1ns/10ps
module fim_link_checker #(
    parameter int PROG_CYCLES = 64
) (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic [3:0] lad,
    input wire logic       lad_host_oe,
    input wire logic       lad_dev_oe,
    input wire logic       lframe_n,
    input wire logic       mode_level,
    input wire logic       mode_connected,
    input wire logic       rst_n,
    input wire logic       init_n,
    input wire logic       oe_n,
    input wire logic       we_n,
    input wire logic       data_dev_oe,
    input wire logic       ready_busy_n
);
    logic [15:0] low_cnt_r;
    logic        parallel;

    assign parallel = mode_connected & mode_level;

    // length of the current busy span
    always_ff @(posedge core_clk) begin
        if (reset || ready_busy_n) begin
            low_cnt_r <= 16'h0000;
        end else begin
            low_cnt_r <= low_cnt_r + 16'h0001;
        end
    end

    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (reset);

    lad_clash_a: assert property (!(lad_host_oe && lad_dev_oe))
        else $error("both ends drive the nibble bus");
    start_frame_a: assert property ($fell(lframe_n) |-> lad == 4'h0)
        else $error("frame opened without start nibble");
    abort_release_a: assert property (!lframe_n |=> !lad_dev_oe)
        else $error("device drives bus after frame");
    sync_first_a: assert property ($rose(lad_dev_oe) |-> lad == 4'h0 && !$past(lad_host_oe))
        else $error("device turn does not open with sync");
    tar_end_a: assert property ($fell(lad_dev_oe) |-> $past(lad) == 4'hF)
        else $error("device released bus without ones");
    float_serial_a: assert property (!mode_connected |-> !data_dev_oe)
        else $error("open strap drives parallel data");
    data_release_a: assert property (oe_n || !parallel |-> !data_dev_oe)
        else $error("data port driven with output enable high");
    busy_start_a: assert property (parallel && $rose(we_n) && ready_busy_n && init_n && rst_n
        |-> ##[1:2] !ready_busy_n)
        else $error("write did not raise busy");
    busy_length_a: assert property ($rose(ready_busy_n) && $past(init_n) && $past(rst_n)
        |-> low_cnt_r == 16'(PROG_CYCLES))
        else $error("busy span length wrong");
    init_quiet_a: assert property (!init_n |=> ready_busy_n && !lad_dev_oe)
        else $error("initialize pin did not reset device");
endmodule // fim_link_checker

// ---- testbench/tb.sv ----
// self-checking bench joining host end and device end of the flash front end
`timescale 1ns/10ps
module tb;
    localparam int PROG = 16;
    typedef struct {logic err; logic chk; logic [7:0] data;} fim_exp_t;

    logic        core_clk = 1'b0;
    logic        reset, cmd_valid, cmd_ready, cmd_write, rsp_valid, rsp_error;
    logic [31:0] cmd_addr;
    logic [7:0]  cmd_wdata, rsp_rdata, d, lo;
    logic        cfg_parallel, cfg_strap_connected, cfg_init_n, dev_ready;
    logic [3:0]  cfg_chip_identity, ident;
    logic [4:0]  cfg_gpi;
    logic [10:0] row, col;
    logic [31:0] pa [3];
    logic [7:0]  pd [3];
    int          n_errors, samples_checked, i;
    integer      seed;
    fim_exp_t    exp_q [$];

    always #2.5 core_clk = ~core_clk;

    fim_if u_fim_if ();
    fim_dev #(.MEM_AW(14), .PROG_CYCLES(PROG)) u_fim_dev (
        .core_clk(core_clk), .reset(reset), .pins(u_fim_if.dev));
    fim_host u_fim_host (
        .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
        .cfg_parallel(cfg_parallel), .cfg_strap_connected(cfg_strap_connected),
        .cfg_chip_identity(cfg_chip_identity), .cfg_gpi(cfg_gpi), .cfg_init_n(cfg_init_n),
        .dev_ready(dev_ready), .pins(u_fim_if.host));
    fim_link_checker #(.PROG_CYCLES(PROG)) u_fim_link_checker (
        .core_clk(core_clk), .reset(reset), .lad(u_fim_if.lad),
        .lad_host_oe(u_fim_if.lad_host_oe), .lad_dev_oe(u_fim_if.lad_dev_oe),
        .lframe_n(u_fim_if.lframe_n), .mode_level(u_fim_if.mode_level),
        .mode_connected(u_fim_if.mode_connected), .rst_n(u_fim_if.rst_n),
        .init_n(u_fim_if.init_n), .oe_n(u_fim_if.oe_n), .we_n(u_fim_if.we_n),
        .data_dev_oe(u_fim_if.data_dev_oe), .ready_busy_n(u_fim_if.ready_busy_n));

    task automatic report_and_stop();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_rsp(input fim_exp_t e, input logic err, input logic [7:0] got);
        samples_checked++;
        if (err !== e.err || (e.chk && got !== e.data)) begin
            n_errors++;
            $display("Error rsp expected %b_%h seen %b_%h", e.err, e.data, err, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    // one command, expected response noted before the take
    task automatic issue(input logic wr, input logic [31:0] a, input logic [7:0] wd,
                         input logic err, input logic chk, input logic [7:0] x);
        fim_exp_t e;
        int k;
        e.err = err;
        e.chk = chk;
        e.data = x;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 100) begin
            @(negedge core_clk);
            k++;
        end
        exp_q.push_back(e);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = wd;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        k = 0;
        while (exp_q.size() != 0 && k < 100) begin
            @(negedge core_clk);
            k++;
        end
        if (exp_q.size() != 0) begin
            n_errors++;
            $display("Error rsp_valid expected 1 seen 0");
            exp_q.delete();
        end
    endtask

    task automatic wait_ready();
        int k;
        k = 0;
        while (dev_ready !== 1'b1 && k < 100) begin
            @(negedge core_clk);
            k++;
        end
        chk_bit("dev_ready", 1'b1, dev_ready);
    endtask

    // strap only changes while reset is held
    task automatic do_reset(input logic par, input logic conn);
        reset = 1'b1;
        cfg_parallel = par;
        cfg_strap_connected = conn;
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
    endtask

    function automatic logic [31:0] saddr(input logic mem, input logic [3:0] id,
                                          input logic [7:0] low);
        return {5'h1F, id, mem, 14'h0000, low};
    endfunction

    always @(posedge core_clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("Error rsp_valid expected 0 seen 1");
            end else begin
                chk_rsp(exp_q.pop_front(), rsp_error, rsp_rdata);
            end
        end
    end

    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        seed = 32'h0607a7b7;
        n_errors = 0;
        samples_checked = 0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 32'h00000000;
        cmd_wdata = 8'h00;
        cfg_init_n = 1'b1;
        ident = $random(seed);
        cfg_chip_identity = ident;
        cfg_gpi = $random(seed);
        do_reset(1'b1, 1'b1);
        // parallel: cells one column bit or one row bit apart keep their own data
        row = $random(seed);
        col = $random(seed);
        pa[0] = {10'h000, col, row};
        pa[1] = {10'h000, col ^ 11'h004, row};
        pa[2] = {10'h000, col, row ^ 11'h020};
        for (i = 0; i < 3; i++) begin
            pd[i] = $random(seed);
            issue(1'b1, pa[i], pd[i], 1'b0, 1'b0, 8'h00);
            wait_ready();
        end
        for (i = 0; i < 3; i++) begin
            issue(1'b0, pa[i], 8'h00, 1'b0, 1'b1, pd[i]);
        end
        // initialize pin cuts a program short
        issue(1'b1, pa[0], 8'hA5, 1'b0, 1'b0, 8'h00);
        chk_bit("dev_ready", 1'b0, dev_ready);
        cfg_init_n = 1'b0;
        @(negedge core_clk);
        cfg_init_n = 1'b1;
        repeat (3) @(negedge core_clk);
        chk_bit("dev_ready", 1'b1, dev_ready);
        do_reset(1'b0, 1'b1);
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            lo = $random(seed);
            issue(1'b1, saddr(1'b1, ident, lo), d, 1'b0, 1'b0, 8'h00);
            wait_ready();
            issue(1'b0, saddr(1'b1, ident, lo), 8'h00, 1'b0, 1'b1, d);
            cfg_gpi = $random(seed);
            issue(1'b0, saddr(1'b0, ident, lo), 8'h00, 1'b0, 1'b1, {3'b000, cfg_gpi});
            issue(1'b0, saddr(1'b1, ident ^ (4'h1 << i), lo), 8'h00, 1'b1, 1'b0, 8'h00);
        end
        // open strap with high level still gives serial
        do_reset(1'b1, 1'b0);
        cfg_gpi = $random(seed);
        issue(1'b0, saddr(1'b0, ident, 8'h00), 8'h00, 1'b0, 1'b1, {3'b000, cfg_gpi});
        report_and_stop();
    end
endmodule // tb
